// ### core/tcrm_regs.svh
// register offsets, field positions, reset values and route codes
`ifndef TCRM_REGS_SVH
`define TCRM_REGS_SVH

`define TCRM_ADDR_W 12
`define TCRM_OFS_TRIG_ROUTE 12'h000
`define TCRM_OFS_FILT_EN_TRIG 12'h040
`define TCRM_OFS_FILT_EN_PFI_LO 12'h044
`define TCRM_OFS_FILT_EN_PFI_HI 12'h048
`define TCRM_OFS_FILT_LEN 12'h04c
`define TCRM_OFS_REFCLK_SEL 12'h050
`define TCRM_OFS_STATUS 12'h054
`define TCRM_OFS_PFI_REF_EN 12'h058
`define TCRM_OFS_DEST_BASE 12'h100

`define TCRM_N_TRIG 8
`define TCRM_N_PFI 40
`define TCRM_N_CTR 8
`define TCRM_N_CTR_IN 8
`define TCRM_N_PFI_REF 16
`define TCRM_N_DEST 70

`define TCRM_OSRC_W 7
`define TCRM_OSRC_NONE 7'h00
`define TCRM_OSRC_DO_SCLK 7'h06
`define TCRM_OSRC_LAST 7'h52
`define TCRM_OSRC_N 83

`define TCRM_ISEL_W 6
`define TCRM_ISEL_STAR 6'h30
`define TCRM_ISEL_CLK100 6'h31
`define TCRM_ISEL_NONE 6'h3f

`define TCRM_DEST_INV_BIT 8
`define TCRM_DEST_EDGE_BIT 9
`define TCRM_REF_PLL_BIT 8
`define TCRM_STAR_FILT_BIT 8
`define TCRM_FILT_LEN_RST 16'h0004

`define TCRM_REF_OSC_HZ 10000000
`define TCRM_PCLK_HZ 10000000

`endif

// ### core/tcrm_pkg.sv
// shared types of the trigger and clock route matrix
package tcrm_pkg;

	typedef struct packed {
		logic edge_mode;
		logic invert;
		logic [5:0] sel;
	} tcrm_dest_cfg_t;

	typedef enum logic [2:0] {
		TCRM_CIN_SOURCE,
		TCRM_CIN_GATE,
		TCRM_CIN_AUX,
		TCRM_CIN_ARM,
		TCRM_CIN_A,
		TCRM_CIN_B,
		TCRM_CIN_Z,
		TCRM_CIN_SCLK
	} tcrm_cin_t;

endpackage

// ### core/tcrm_debounce.sv
// debounce filter for one routed input line
`timescale 1ns/1ps
module tcrm_debounce #(
	parameter int FILT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic filt_en,
	input wire logic [FILT_W-1:0] filt_len,
	input wire logic din,
	output logic dout
);

	logic [FILT_W-1:0] cnt_q;
	logic dout_q;

	// a change must hold filt_len cycles before it is passed on
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= '0;
			dout_q <= 1'b0;
		end else if (ce) begin
			if (!filt_en || din == dout_q) begin
				cnt_q <= '0;
				if (!filt_en) begin
					dout_q <= din;
				end
			end else if (cnt_q + 1'b1 >= filt_len) begin
				cnt_q <= '0;
				dout_q <= din;
			end else begin
				cnt_q <= cnt_q + 1'b1;
			end
		end
	end

	assign dout = dout_q;

endmodule

// ### core/tcrm_matrix.sv
// trigger and clock route matrix with apb register access
`timescale 1ns/1ps
`include "tcrm_regs.svh"
module tcrm_matrix #(
	parameter int FILT_W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [`TCRM_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [`TCRM_N_TRIG-1:0] inter_board_trigger_line_in,
	output logic [`TCRM_N_TRIG-1:0] inter_board_trigger_line_out,
	output logic [`TCRM_N_TRIG-1:0] inter_board_trigger_line_oe,
	input wire logic [`TCRM_N_PFI-1:0] programmable_function_line_in,
	output logic [`TCRM_N_PFI_REF-1:0] programmable_function_line_out,
	output logic [`TCRM_N_PFI_REF-1:0] programmable_function_line_oe,
	input wire logic star_trigger_in,
	input wire logic chassis_clk100_in,
	input wire logic onboard_osc_10mhz,
	input wire logic [3:0] di_trig_src,
	input wire logic [2:0] do_trig_src,
	input wire logic [`TCRM_N_CTR-1:0] ctr_source_src,
	input wire logic [`TCRM_N_CTR-1:0] ctr_gate_src,
	input wire logic [`TCRM_N_CTR-1:0] ctr_z_src,
	input wire logic [`TCRM_N_CTR-1:0] ctr_output_src,
	input wire logic change_detect_src,
	input wire logic freq_out_src,
	output logic [`TCRM_N_CTR-1:0] counter_source_input,
	output logic [`TCRM_N_CTR-1:0] counter_gate_input,
	output logic [`TCRM_N_CTR-1:0] counter_auxiliary_input,
	output logic [`TCRM_N_CTR-1:0] hardware_arm_input,
	output logic [`TCRM_N_CTR-1:0] counter_a_input,
	output logic [`TCRM_N_CTR-1:0] counter_b_input,
	output logic [`TCRM_N_CTR-1:0] counter_z_input,
	output logic [`TCRM_N_CTR-1:0] counter_sample_clock_input,
	output logic input_sample_clock,
	output logic input_start_trigger,
	output logic input_pause_trigger,
	output logic input_reference_trigger,
	output logic output_sample_clock,
	output logic output_sample_timebase,
	output logic pll_ref_clk,
	output logic pll_enable
);

	if (FILT_W < 1 || FILT_W > 16) begin : g_chk
		$error("tcrm_matrix: FILT_W must be 1 to 16");
	end

	localparam int NFL = `TCRM_N_TRIG + `TCRM_N_PFI + 1;

	// configuration state
	logic [`TCRM_OSRC_W-1:0] route_q [`TCRM_N_TRIG];
	tcrm_pkg::tcrm_dest_cfg_t dest_q [`TCRM_N_DEST];
	logic [NFL-1:0] filt_en_q;
	logic [FILT_W-1:0] filt_len_q;
	logic [`TCRM_ISEL_W-1:0] ref_sel_q;
	logic pll_en_q;
	logic [`TCRM_N_PFI_REF-1:0] pfi_ref_en_q;

	// apb handshake state
	logic acc_q;
	logic [31:0] prdata_q;
	logic [31:0] rd_mux;
	logic addr_ok;
	logic wr_fire;
	logic [11:0] dest_ofs;
	logic [6:0] dest_idx;
	logic is_dest;
	logic is_route;
	logic [2:0] route_idx;

	// routing datapath
	logic [NFL-1:0] raw_lines;
	logic [NFL-1:0] filt_lines;
	logic [63:0] isrc_vec;
	logic [`TCRM_OSRC_N-1:0] osrc_vec;
	logic [`TCRM_N_DEST-1:0] dest_lvl;
	logic [`TCRM_N_DEST-1:0] dest_prev_q;
	logic [`TCRM_N_DEST-1:0] dest_out_q;
	logic [`TCRM_N_TRIG-1:0] trig_out_q;
	logic [`TCRM_N_TRIG-1:0] trig_oe_q;
	logic [`TCRM_N_PFI_REF-1:0] pfi_out_q;
	logic pll_ref_q;

	// address decode
	assign dest_ofs = paddr - `TCRM_OFS_DEST_BASE;
	assign dest_idx = dest_ofs[8:2];
	assign is_dest = (paddr >= `TCRM_OFS_DEST_BASE) && (paddr[1:0] == 2'b00)
		&& (dest_ofs[11:9] == 3'b000) && (dest_idx < 7'(`TCRM_N_DEST));
	assign is_route = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
	assign route_idx = paddr[4:2];

	always_comb begin
		addr_ok = 1'b1;
		rd_mux = 32'h0000_0000;
		if (is_route) begin
			rd_mux[`TCRM_OSRC_W-1:0] = route_q[route_idx];
		end else if (is_dest) begin
			rd_mux[5:0] = dest_q[dest_idx].sel;
			rd_mux[`TCRM_DEST_INV_BIT] = dest_q[dest_idx].invert;
			rd_mux[`TCRM_DEST_EDGE_BIT] = dest_q[dest_idx].edge_mode;
		end else begin
			unique case (paddr)
				`TCRM_OFS_FILT_EN_TRIG: rd_mux[7:0] = filt_en_q[7:0];
				`TCRM_OFS_FILT_EN_PFI_LO: rd_mux = filt_en_q[39:8];
				`TCRM_OFS_FILT_EN_PFI_HI: rd_mux[8:0] = filt_en_q[48:40];
				`TCRM_OFS_FILT_LEN: rd_mux[FILT_W-1:0] = filt_len_q;
				`TCRM_OFS_REFCLK_SEL: begin
					rd_mux[`TCRM_ISEL_W-1:0] = ref_sel_q;
					rd_mux[`TCRM_REF_PLL_BIT] = pll_en_q;
				end
				`TCRM_OFS_STATUS: begin
					rd_mux[7:0] = filt_lines[7:0];
					rd_mux[15:8] = trig_oe_q;
					rd_mux[16] = filt_lines[NFL-1];
					rd_mux[17] = pll_en_q;
				end
				`TCRM_OFS_PFI_REF_EN: rd_mux[15:0] = pfi_ref_en_q;
				default: addr_ok = 1'b0;
			endcase
		end
	end

	// read data is captured in the first enabled cycle of a transfer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else if (ce) begin
			if (psel && penable && acc_q) begin
				acc_q <= 1'b0;
			end else if (psel) begin
				acc_q <= 1'b1;
				prdata_q <= rd_mux;
			end
		end
	end

	assign pready = psel & penable & ce & acc_q;
	assign pslverr = pready & ~addr_ok;
	assign prdata = prdata_q;
	assign wr_fire = pready & pwrite & addr_ok;

	// trigger output route registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `TCRM_N_TRIG; i++) begin
				route_q[i] <= `TCRM_OSRC_NONE;
			end
		end else if (ce && wr_fire && is_route) begin
			route_q[route_idx] <= pwdata[`TCRM_OSRC_W-1:0];
		end
	end

	// per-destination select, polarity and edge/level mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `TCRM_N_DEST; i++) begin
				dest_q[i] <= '{edge_mode: 1'b0, invert: 1'b0,
					sel: `TCRM_ISEL_NONE};
			end
		end else if (ce && wr_fire && is_dest) begin
			dest_q[dest_idx] <= '{edge_mode: pwdata[`TCRM_DEST_EDGE_BIT],
				invert: pwdata[`TCRM_DEST_INV_BIT],
				sel: pwdata[5:0]};
		end
	end

	// filter, reference clock and pfi reference controls
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			filt_en_q <= '0;
			filt_len_q <= FILT_W'(`TCRM_FILT_LEN_RST);
			ref_sel_q <= `TCRM_ISEL_NONE;
			pll_en_q <= 1'b0;
			pfi_ref_en_q <= '0;
		end else if (ce && wr_fire) begin
			unique case (paddr)
				`TCRM_OFS_FILT_EN_TRIG: filt_en_q[7:0] <= pwdata[7:0];
				`TCRM_OFS_FILT_EN_PFI_LO: filt_en_q[39:8] <= pwdata;
				`TCRM_OFS_FILT_EN_PFI_HI: filt_en_q[48:40] <= pwdata[8:0];
				`TCRM_OFS_FILT_LEN: filt_len_q <= pwdata[FILT_W-1:0];
				`TCRM_OFS_REFCLK_SEL: begin
					ref_sel_q <= pwdata[`TCRM_ISEL_W-1:0];
					pll_en_q <= pwdata[`TCRM_REF_PLL_BIT];
				end
				`TCRM_OFS_PFI_REF_EN: pfi_ref_en_q <= pwdata[15:0];
				default: ;
			endcase
		end
	end

	// debounce on every trigger line, pfi line and the star input
	assign raw_lines = {star_trigger_in, programmable_function_line_in,
		inter_board_trigger_line_in};

	for (genvar f = 0; f < NFL; f++) begin : g_filt
		tcrm_debounce #(
			.FILT_W(FILT_W)
		) u_filt (
			.pclk(pclk),
			.presetn(presetn),
			.ce(ce),
			.filt_en(filt_en_q[f]),
			.filt_len(filt_len_q),
			.din(raw_lines[f]),
			.dout(filt_lines[f])
		);
	end

	// input select space: trigger, pfi, star, chassis clock
	assign isrc_vec = {14'h0000, chassis_clk100_in, filt_lines};

	// output source space, in route code order
	assign osrc_vec = {programmable_function_line_in, freq_out_src,
		change_detect_src, ctr_output_src, ctr_z_src, ctr_gate_src,
		ctr_source_src, onboard_osc_10mhz, do_trig_src, di_trig_src,
		1'b0};

	// destination inputs: polarity first, then edge pulse or level
	for (genvar d = 0; d < `TCRM_N_DEST; d++) begin : g_dest
		assign dest_lvl[d] = (dest_q[d].sel <= `TCRM_ISEL_CLK100) &
			(isrc_vec[dest_q[d].sel] ^ dest_q[d].invert);

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				dest_prev_q[d] <= 1'b0;
				dest_out_q[d] <= 1'b0;
			end else if (ce) begin
				dest_prev_q[d] <= dest_lvl[d];
				if (dest_q[d].edge_mode) begin
					dest_out_q[d] <= dest_lvl[d] & ~dest_prev_q[d];
				end else begin
					dest_out_q[d] <= dest_lvl[d];
				end
			end
		end
	end

	// counter c owns destinations c*8 .. c*8+7 in input order
	for (genvar c = 0; c < `TCRM_N_CTR; c++) begin : g_ctr
		localparam int B = c * `TCRM_N_CTR_IN;
		assign counter_source_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_SOURCE)];
		// pause and count-reset both arrive through the gate
		assign counter_gate_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_GATE)];
		assign counter_auxiliary_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_AUX)];
		assign hardware_arm_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_ARM)];
		assign counter_a_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_A)];
		assign counter_b_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_B)];
		assign counter_z_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_Z)];
		assign counter_sample_clock_input[c] =
			dest_out_q[B + int'(tcrm_pkg::TCRM_CIN_SCLK)];
	end

	assign input_sample_clock = dest_out_q[64];
	assign input_start_trigger = dest_out_q[65];
	assign input_pause_trigger = dest_out_q[66];
	assign input_reference_trigger = dest_out_q[67];
	assign output_sample_clock = dest_out_q[68];
	assign output_sample_timebase = dest_out_q[69];

	// trigger line drivers; an out-of-range code drives nothing
	for (genvar t = 0; t < `TCRM_N_TRIG; t++) begin : g_trig
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				trig_out_q[t] <= 1'b0;
				trig_oe_q[t] <= 1'b0;
			end else if (ce) begin
				if (route_q[t] == `TCRM_OSRC_NONE ||
					route_q[t] > `TCRM_OSRC_LAST) begin
					trig_out_q[t] <= 1'b0;
					trig_oe_q[t] <= 1'b0;
				end else begin
					trig_out_q[t] <= osrc_vec[route_q[t]] ^
						(route_q[t] == `TCRM_OSRC_DO_SCLK);
					trig_oe_q[t] <= 1'b1;
				end
			end
		end
	end

	assign inter_board_trigger_line_out = trig_out_q;
	assign inter_board_trigger_line_oe = trig_oe_q;

	// low pfi lines can carry the 10 mhz reference to other boards
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pfi_out_q <= '0;
		end else if (ce) begin
			pfi_out_q <= pfi_ref_en_q & {`TCRM_N_PFI_REF{onboard_osc_10mhz}};
		end
	end

	assign programmable_function_line_out = pfi_out_q;
	assign programmable_function_line_oe = pfi_ref_en_q;

	// external reference select: trigger, pfi, star or chassis 100 mhz
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pll_ref_q <= 1'b0;
		end else if (ce) begin
			pll_ref_q <= (ref_sel_q != `TCRM_ISEL_NONE) &
				isrc_vec[ref_sel_q];
		end
	end

	// sampled copy only; a real clock path bypasses this register
	assign pll_ref_clk = pll_ref_q;
	assign pll_enable = pll_en_q & (ref_sel_q <= `TCRM_ISEL_CLK100);

endmodule

// ### tb/tcrm_matrix_assertions.sv
// port assertions for the route matrix
`timescale 1ns/1ps
module tcrm_matrix_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [7:0] inter_board_trigger_line_oe,
	input wire logic [15:0] programmable_function_line_out,
	input wire logic [15:0] programmable_function_line_oe,
	input wire logic onboard_osc_10mhz,
	input wire logic pll_enable
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_rdy_access;
		pready |-> psel && penable && ce;
	endproperty
	a_rdy_access: assert property (p_rdy_access)
		else $error("pready outside access");
	property p_err_rdy;
		pslverr |-> pready;
	endproperty
	a_err_rdy: assert property (p_err_rdy)
		else $error("pslverr without pready");
	property p_zero_wait;
		psel && !penable && ce ##1 penable && ce |-> pready;
	endproperty
	a_zero_wait: assert property (p_zero_wait)
		else $error("access not answered");
	property p_hold_rd;
		!(psel && ce && !pready) |=> $stable(prdata);
	endproperty
	a_hold_rd: assert property (p_hold_rd)
		else $error("prdata moved");
	property p_ce_wait;
		!ce |-> !pready;
	endproperty
	a_ce_wait: assert property (p_ce_wait)
		else $error("pready while frozen");
	property p_oe_wr;
		(inter_board_trigger_line_oe & ~$past(inter_board_trigger_line_oe))
			!= 8'h00 |-> $past(pready && pwrite, 2);
	endproperty
	a_oe_wr: assert property (p_oe_wr)
		else $error("line driven without route write");
	property p_pfi_osc;
		$past(ce) && $stable(programmable_function_line_oe) |->
			(programmable_function_line_out & programmable_function_line_oe)
			== ({16{$past(onboard_osc_10mhz)}} & programmable_function_line_oe);
	endproperty
	a_pfi_osc: assert property (p_pfi_osc)
		else $error("pfi reference not oscillator");
	property p_pll_wr;
		$changed(pll_enable) |-> $past(pready && pwrite);
	endproperty
	a_pll_wr: assert property (p_pll_wr)
		else $error("pll enable moved alone");
endmodule

// ### tb/tcrm_far_side.sv
// other instruments on the shared trigger and clock lines
`timescale 1ns/1ps
module tcrm_far_side (
	input wire logic pclk,
	input wire logic [7:0] line_out,
	input wire logic [7:0] line_oe,
	input wire logic [7:0] drive_en,
	input wire logic [7:0] drive_lvl,
	output logic [7:0] line,
	output logic star_clk,
	output logic clk100
);
	logic [7:0] junk_q = 8'h5a;
	initial star_clk = 1'b0;
	initial clk100 = 1'b0;
	// released lines flip every cycle so a stale level never passes
	always @(posedge pclk) begin
		junk_q <= ~junk_q;
		clk100 <= ~clk100;
		star_clk <= star_clk ^ clk100;
	end
	// we only drive where the device has let go
	assign line = (line_oe & line_out) | (~line_oe & drive_en & drive_lvl)
		| (~line_oe & ~drive_en & junk_q);
endmodule

// ### tb/trigger_clock_route_matrix_test.sv
// self-checking bench for the route matrix
`timescale 1ns/1ps
module trigger_clock_route_matrix_test;
	logic pclk = 1'b0, presetn = 1'b0, ce = 1'b1, osc = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, n;
	logic pready, pslverr, er, star, clk100, pll_ref, pll_en, pr;
	logic [3:0] di = 4'h0;
	logic [2:0] dos = 3'h0;
	logic [7:0] cs = 8'h00, oe8, out8, line, den = 8'h00, dlv = 8'h00;
	logic [7:0] cin [8];
	logic [5:0] ts;
	logic [39:0] programmable_function_line = 40'h0;
	logic [15:0] pout, poe;
	int failures = 0, checks_done = 0;
	always #50 pclk = ~pclk;
	tcrm_matrix dut (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr,
		.inter_board_trigger_line_in(line),
		.inter_board_trigger_line_out(out8),
		.inter_board_trigger_line_oe(oe8),
		.programmable_function_line_in(programmable_function_line),
		.programmable_function_line_out(pout),
		.programmable_function_line_oe(poe),
		.star_trigger_in(star), .chassis_clk100_in(clk100),
		.onboard_osc_10mhz(osc), .di_trig_src(di), .do_trig_src(dos),
		.ctr_source_src(cs), .ctr_gate_src(cs), .ctr_z_src(cs),
		.ctr_output_src(cs), .change_detect_src(cs[0]),
		.freq_out_src(cs[1]), .counter_source_input(cin[0]),
		.counter_gate_input(cin[1]), .counter_auxiliary_input(cin[2]),
		.hardware_arm_input(cin[3]), .counter_a_input(cin[4]),
		.counter_b_input(cin[5]), .counter_z_input(cin[6]),
		.counter_sample_clock_input(cin[7]), .input_sample_clock(ts[0]),
		.input_start_trigger(ts[1]), .input_pause_trigger(ts[2]),
		.input_reference_trigger(ts[3]), .output_sample_clock(ts[4]),
		.output_sample_timebase(ts[5]), .pll_ref_clk(pll_ref),
		.pll_enable(pll_en));
	tcrm_far_side far (.pclk, .line_out(out8), .line_oe(oe8),
		.drive_en(den), .drive_lvl(dlv), .line, .star_clk(star), .clk100);
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	// the bus waits for pready however long it takes
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic wt(input int c);
		repeat (c) @(posedge pclk);
	endtask
	task automatic setsrc(input logic s);
		di <= {4{s}};
		dos <= {3{s}};
		cs <= {8{s}};
		programmable_function_line <= {40{s}};
		osc <= s;
	endtask
	initial begin
		wt(20);
		presetn <= 1'b1;
		wt(1);
		apb(1'b0, 12'h04c, 32'h0);
		chk(rd, 32'h4);
		apb(1'b0, 12'h050, 32'h0);
		chk(rd, 32'h3f);
		apb(1'b0, 12'h100, 32'h0);
		chk(rd, 32'h3f);
		apb(1'b0, 12'h0f0, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		ce <= 1'b0;
		wt(3);
		ce <= 1'b1;
		for (int c = 1; c < 83; c++) begin
			setsrc(c[0]);
			wr(12'h010, 32'(c));
			wt(4);
			chk(out8[4], (c == 6) ? !c[0] : c[0]);
		end
		wr(12'h00c, 32'h53);
		wr(12'h010, 32'h0);
		wr(12'h004, 32'h8);
		wt(3);
		chk(oe8, 8'h02);
		apb(1'b0, 12'h054, 32'h0);
		chk(rd[15:8], 8'h02);
		den <= 8'h20;
		dlv <= 8'h20;
		for (int d = 0; d < 70; d++)
			if (d < 8 || d == 57 || d > 63)
				wr(12'(256 + 4 * d), 32'(5 + 256 * (d % 2)));
		wt(4);
		for (int k = 0; k < 8; k++)
			chk(cin[k][0], !k[0]);
		chk(ts, 6'h15);
		chk(cin[1][7], 1'b0);
		dlv <= 8'h00;
		wt(4);
		for (int k = 0; k < 8; k++)
			chk(cin[k][0], k[0]);
		chk(ts, 6'h2a);
		chk(cin[1][7], 1'b1);
		// gate as pause source in edge mode gives one pulse per rise
		wr(12'h104, 32'h205);
		wt(4);
		dlv <= 8'h20;
		n = 0;
		repeat (8) begin
			@(posedge pclk);
			n = n + cin[1][0];
		end
		chk(n, 32'h1);
		wr(12'h040, 32'h20);
		dlv <= 8'h00;
		wt(3);
		chk(cin[0][0], 1'b1);
		dlv <= 8'h20;
		wt(6);
		chk(cin[0][0], 1'b1);
		dlv <= 8'h00;
		wt(3);
		chk(cin[0][0], 1'b1);
		wt(5);
		chk(cin[0][0], 1'b0);
		for (int s = 0; s < 2; s++) begin
			wr(12'h050, 32'(304 + s));
			wt(2);
			n = 0;
			pr = pll_ref;
			repeat (12) begin
				@(posedge pclk);
				n = n + (pll_ref !== pr);
				pr = pll_ref;
			end
			chk({pll_en, n > 3}, 2'b11);
		end
		wr(12'h050, 32'h13f);
		wt(2);
		chk(pll_en, 1'b0);
		wr(12'h048, 32'h100);
		apb(1'b0, 12'h048, 32'h0);
		chk(rd, 32'h100);
		wr(12'h058, 32'h1);
		osc <= 1'b1;
		wt(3);
		chk({poe[0], pout[0]}, 2'b11);
		report_and_stop();
	end
	initial begin
		#3000000;
		failures++;
		report_and_stop();
	end
endmodule
bind tcrm_matrix tcrm_matrix_assertions chk_i (.pclk, .presetn, .ce,
	.psel, .penable, .pwrite, .prdata, .pready, .pslverr,
	.inter_board_trigger_line_oe, .programmable_function_line_out,
	.programmable_function_line_oe, .onboard_osc_10mhz, .pll_enable);
